// ===== verification/strap_board.sv
// Board strap resistors and MAC drive on the shared pins
`timescale 1ns/100ps
`default_nettype none
module strap_board
  import strap_cfg_pkg::*;
(
  input wire logic [PIN_COUNT-1:0] i_strap_up,
  input wire logic i_mac_tx_data_bit4,
  input wire logic [PIN_COUNT-1:0] i_pad,
  input wire logic [PIN_COUNT-1:0] i_pad_oe_n,
  output logic [PIN_COUNT-1:0] o_level
);
  always_comb
  begin
    for (int i = 0; i < PIN_IRQ; i++)
      o_level[i] = i_pad_oe_n[i] ? i_strap_up[i] : i_pad[i];
    // Pull-up only in interrupt mode, else the MAC drives it
    o_level[PIN_IRQ] = !i_pad_oe_n[PIN_IRQ] ? i_pad[PIN_IRQ] :
      (i_strap_up[PIN_IRQSEL] ? 1'b1 : i_mac_tx_data_bit4);
  end
endmodule
`default_nettype wire

// ===== verification/test_strap_config_latch.sv
// Self-checking bench for the boot-strap configuration latch
`timescale 1ns/100ps
`default_nettype none
module test_strap_config_latch;
  import strap_cfg_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ext_n = 1'b0;
  logic irq_n = 1'b1;
  logic tx_data_bit4 = 1'b0;
  logic [10:0] func = 11'h000;
  logic [11:0] up = 12'h100;
  logic [11:0] lvl;
  logic [11:0] pad;
  logic [11:0] oe_n;
  logic tx4;
  logic core_regulator_disable_strap;
  logic rmii;
  logic irqsel;
  logic valid;
  logic [4:0] addr;
  logic [2:0] mode;
  int failures = 0;
  int checks_done = 0;
  always #25 clk = ~clk;
  strap_config_latch u_strap_config_latch (.i_clk(clk), .i_rst_n(rst_n),
    .i_ext_reset_n(ext_n), .i_pad(lvl), .o_pad(pad), .o_pad_oe_n(oe_n),
    .i_func_out(func), .i_irq_out_n(irq_n), .o_tx_data_bit4(tx4),
    .o_mgmt_addr(addr), .o_op_mode(mode), .o_core_regulator_disable(core_regulator_disable_strap),
    .o_rmii_select(rmii), .o_irq_pin_function_select(irqsel), .o_cfg_valid(valid));
  strap_board u_strap_board (.i_strap_up(up), .i_mac_tx_data_bit4(tx_data_bit4), .i_pad(pad),
    .i_pad_oe_n(oe_n), .o_level(lvl));
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string name, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task fields(input logic [11:0] s);
    chk("addr", 12'(s[PIN_ADDR4:PIN_ADDR0]), 12'(addr));
    chk("mode", 12'(s[PIN_OP_MODE_STRAP_BIT2:PIN_OP_MODE_STRAP_BIT0]), 12'(mode));
    chk("core_regulator_disable_strap", 12'(s[PIN_CORE_REGULATOR_DISABLE_STRAP]), 12'(core_regulator_disable_strap));
    chk("rmii", 12'(s[PIN_RMII]), 12'(rmii));
    chk("irqsel", 12'(s[PIN_IRQSEL]), 12'(irqsel));
  endtask
  task release_cfg(input logic [11:0] s);
    int k;
    up = s;
    ext_n = 1'b0;
    step(4);
    ext_n = 1'b1;
    k = 0;
    while (valid !== 1'b1 && k < 10)
    begin
      step(1);
      k++;
    end
    // A release that never completes ends the run
    if (k == 10)
    begin
      failures++;
      end_sim();
    end
    else
    begin
      chk("latency", 12'h003, 12'(k));
      fields(s);
      chk("oe_n", {~s[PIN_IRQSEL], 11'h000}, oe_n);
    end
  endtask
  task test_modes;
    for (int m = 0; m < 8; m++)
      release_cfg({m[0], m[0], m[1], 1'b1, 3'(m), 5'h1f ^ 5'(m * 9)});
    func = 11'h5a5;
    irq_n = 1'b0;
    step(1);
    chk("pad", {irq_n, func}, pad);
    $display("test_modes done");
  endtask
  task test_tx_data_bit4;
    release_cfg(12'h255);
    tx_data_bit4 = 1'b1;
    step(3);
    chk("tx_data_bit4", 12'h001, 12'(tx4));
    tx_data_bit4 = 1'b0;
    step(3);
    chk("tx_data_bit4", 12'h000, 12'(tx4));
    $display("test_tx_data_bit4 done");
  endtask
  task test_hold;
    release_cfg(12'h4ea);
    // Straps flip while running and must be ignored
    up = ~12'h4ea;
    step(6);
    fields(12'h4ea);
    ext_n = 1'b0;
    step(4);
    chk("valid", 12'h000, 12'(valid));
    fields(12'h4ea);
    rst_n = 1'b0;
    step(3);
    fields(12'h100);
    rst_n = 1'b1;
    step(3);
    $display("test_hold done");
  endtask
  initial
  begin
    step(20);
    rst_n = 1'b1;
    step(2);
    test_modes();
    test_tx_data_bit4();
    test_hold();
    end_sim();
  end
endmodule
`default_nettype wire

// ===== verilog/strap_cfg_pkg.sv
// Shared constants for the boot-strap configuration latch
package strap_cfg_pkg;
  localparam int PIN_COUNT = 12;
  localparam int SYNC_STAGES = 2;
  // Shared pin positions on the pad vector
  localparam int PIN_ADDR0 = 0;
  localparam int PIN_ADDR1 = 1;
  localparam int PIN_ADDR2 = 2;
  localparam int PIN_ADDR3 = 3;
  localparam int PIN_ADDR4 = 4;
  localparam int PIN_OP_MODE_STRAP_BIT0 = 5;
  localparam int PIN_OP_MODE_STRAP_BIT1 = 6;
  localparam int PIN_OP_MODE_STRAP_BIT2 = 7;
  localparam int PIN_IRQSEL = 8;
  localparam int PIN_CORE_REGULATOR_DISABLE_STRAP = 9;
  localparam int PIN_RMII = 10;
  localparam int PIN_IRQ = 11;
  localparam int ADDR_W = 5;
  localparam int MODE_W = 3;
  // Values held from chip reset until the first release
  localparam logic [ADDR_W-1:0] ADDR_RST = 5'h00;
  localparam logic [MODE_W-1:0] MODE_RST = 3'h0;
  localparam logic CORE_REGULATOR_DISABLE_STRAP_RST = 1'h0;
  localparam logic RMII_RST = 1'h0;
  localparam logic IRQSEL_RST = 1'h1;
  localparam logic [PIN_COUNT-1:0] PADS_RST = 12'h000;
  localparam logic [PIN_COUNT-1:0] OE_N_ALL_OFF = 12'hfff;

  typedef enum logic [0:0] {
    ST_HELD = 1'b0,
    ST_RUN = 1'b1
  } latch_state_e;
endpackage

// ===== verilog/strap_config_latch.sv
// Boot-strap configuration latch for shared PHY pins
// Functional notes
// - Sample all straps at external reset release
// - Management address from five shared strap pins
// - Operating mode from receive data straps
// - Pulled-up receive clock strap disables regulator
// - Pulled-up collision strap selects RMII
// - Floating data-3 strap makes interrupt pin
// - Shared pins resume normal function after sampling
`timescale 1ns/100ps
`default_nettype none
module strap_config_latch
  import strap_cfg_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ext_reset_n,
  input wire logic [PIN_COUNT-1:0] i_pad,
  output logic [PIN_COUNT-1:0] o_pad,
  output logic [PIN_COUNT-1:0] o_pad_oe_n,
  input wire logic [PIN_COUNT-2:0] i_func_out,
  input wire logic i_irq_out_n,
  output logic o_tx_data_bit4,
  output logic [ADDR_W-1:0] o_mgmt_addr,
  output logic [MODE_W-1:0] o_op_mode,
  output logic o_core_regulator_disable,
  output logic o_rmii_select,
  output logic o_irq_pin_function_select,
  output logic o_cfg_valid
);
  if (STAGES < 2)
  begin : g_bad_stages
    $error("strap_config_latch needs at least two sync stages");
  end

  strap_sync_if sync_bus ();

  assign sync_bus.raw = i_pad;
  assign sync_bus.ext_raw = i_ext_reset_n;

  strap_sync #(
    .STAGES(STAGES)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .bus(sync_bus)
  );

  latch_state_e state_r;
  latch_state_e state_nxt;
  logic ext_prev_r;
  logic release_seen;
  logic [ADDR_W-1:0] addr_r;
  logic [MODE_W-1:0] mode_r;
  logic core_regulator_disable_strap_r;
  logic rmii_r;
  logic irqsel_r;
  logic valid_r;
  logic [PIN_COUNT-1:0] pad_out_r;
  logic [PIN_COUNT-1:0] oe_n_r;
  logic tx_data_bit4_r;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ext_prev_r <= 1'b0;
    end
    else
    begin
      ext_prev_r <= sync_bus.ext_sync;
    end
  end

  assign release_seen = sync_bus.ext_sync && !ext_prev_r;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_HELD:
      begin
        if (release_seen)
        begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (!sync_bus.ext_sync)
        begin
          state_nxt = ST_HELD;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_r <= ST_HELD;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // Capture only on the release edge; later pin indicator_a never reaches these
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      addr_r <= ADDR_RST;
      mode_r <= MODE_RST;
      core_regulator_disable_strap_r <= CORE_REGULATOR_DISABLE_STRAP_RST;
      rmii_r <= RMII_RST;
      irqsel_r <= IRQSEL_RST;
    end
    else if (release_seen)
    begin
      addr_r <= {sync_bus.pads[PIN_ADDR4], sync_bus.pads[PIN_ADDR3],
                 sync_bus.pads[PIN_ADDR2], sync_bus.pads[PIN_ADDR1],
                 sync_bus.pads[PIN_ADDR0]};
      mode_r <= {sync_bus.pads[PIN_OP_MODE_STRAP_BIT2], sync_bus.pads[PIN_OP_MODE_STRAP_BIT1],
                 sync_bus.pads[PIN_OP_MODE_STRAP_BIT0]};
      // Floating pins read low here: pad keeper assumed to pull down
      core_regulator_disable_strap_r <= sync_bus.pads[PIN_CORE_REGULATOR_DISABLE_STRAP];
      rmii_r <= sync_bus.pads[PIN_RMII];
      // This pad has a weak pull-up, so floating reads as interrupt mode
      irqsel_r <= sync_bus.pads[PIN_IRQSEL];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      valid_r <= 1'b0;
    end
    else
    begin
      valid_r <= (state_nxt == ST_RUN);
    end
  end

  // Pads float while held so board straps set the level unopposed
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      oe_n_r <= OE_N_ALL_OFF;
      pad_out_r <= PADS_RST;
    end
    else if (state_nxt == ST_RUN)
    begin
      oe_n_r <= {!irqsel_nxt(), {(PIN_COUNT-1){1'b0}}};
      pad_out_r <= {i_irq_out_n, i_func_out};
    end
    else
    begin
      oe_n_r <= OE_N_ALL_OFF;
      pad_out_r <= PADS_RST;
    end
  end

  // Selection in force next cycle, including the one being latched now
  function automatic logic irqsel_nxt();
    return release_seen ? sync_bus.pads[PIN_IRQSEL] : irqsel_r;
  endfunction

  // Transmit bit 4 only meaningful when the pin is an input
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      tx_data_bit4_r <= 1'b0;
    end
    else
    begin
      tx_data_bit4_r <= (state_r == ST_RUN) && !irqsel_r && sync_bus.pads[PIN_IRQ];
    end
  end

  assign o_pad = pad_out_r;
  assign o_pad_oe_n = oe_n_r;
  assign o_tx_data_bit4 = tx_data_bit4_r;
  assign o_mgmt_addr = addr_r;
  assign o_op_mode = mode_r;
  assign o_core_regulator_disable = core_regulator_disable_strap_r;
  assign o_rmii_select = rmii_r;
  assign o_irq_pin_function_select = irqsel_r;
  assign o_cfg_valid = valid_r;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_SAMPLE_ON_RELEASE: assert property (
    $rose(sync_bus.ext_sync) |=> o_cfg_valid ##1 o_cfg_valid)
    else $error("Config not valid after reset release");

  AST_ADDR_MAP: assert property (
    release_seen |=> o_mgmt_addr == {$past(sync_bus.pads[PIN_ADDR4]),
      $past(sync_bus.pads[PIN_ADDR3]), $past(sync_bus.pads[PIN_ADDR2]),
      $past(sync_bus.pads[PIN_ADDR1]), $past(sync_bus.pads[PIN_ADDR0])})
    else $error("Management address differs from straps");

  AST_MODE_MAP: assert property (
    release_seen |=> o_op_mode == {$past(sync_bus.pads[PIN_OP_MODE_STRAP_BIT2]),
      $past(sync_bus.pads[PIN_OP_MODE_STRAP_BIT1]), $past(sync_bus.pads[PIN_OP_MODE_STRAP_BIT0])})
    else $error("Operating mode differs from straps");

  AST_CORE_REGULATOR_DISABLE_STRAP_MAP: assert property (
    release_seen |=> o_core_regulator_disable == $past(sync_bus.pads[PIN_CORE_REGULATOR_DISABLE_STRAP]))
    else $error("Regulator disable differs from strap");

  AST_RMII_MAP: assert property (
    release_seen |=> o_rmii_select == $past(sync_bus.pads[PIN_RMII]))
    else $error("Interface select differs from strap");

  AST_IRQ_PIN_DRIVE: assert property (
    o_cfg_valid |-> o_pad_oe_n[PIN_IRQ] == !o_irq_pin_function_select)
    else $error("Interrupt pin drive disagrees with selection");

  // Only while the pin stays released; a falling pin floats the pads next cycle
  AST_NORMAL_FUNCTION: assert property (
    (state_r == ST_RUN && $past(state_r == ST_RUN) && sync_bus.ext_sync) |->
      o_pad_oe_n[PIN_COUNT-2:0] == '0 ##1 o_pad[PIN_COUNT-2:0] == $past(i_func_out))
    else $error("Shared pins not returned to normal function");

  AST_FLOAT_WHILE_HELD: assert property (
    !sync_bus.ext_sync |=> o_pad_oe_n == OE_N_ALL_OFF && !o_cfg_valid)
    else $error("Pads driven during external reset");

  AST_HOLD_VALUES: assert property (
    !release_seen |=> $stable({o_mgmt_addr, o_op_mode, o_core_regulator_disable,
      o_rmii_select, o_irq_pin_function_select}))
    else $error("Latched configuration changed without release");
endmodule
`default_nettype wire

// ===== verilog/strap_sync.sv
// Multi-stage synchroniser for strap pins and the external reset pin
`timescale 1ns/100ps
`default_nettype none
module strap_sync
  import strap_cfg_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
)
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  strap_sync_if.sync_side bus
);
  // Fewer than two stages would leak metastability into the latch
  if (STAGES < 2)
  begin : g_bad_stages
    $error("strap_sync needs at least two stages");
  end

  logic [PIN_COUNT:0] stage_r [STAGES];

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      for (int k = 0; k < STAGES; k++)
      begin
        stage_r[k] <= {1'b0, PADS_RST};
      end
    end
    else
    begin
      stage_r[0] <= {bus.ext_raw, bus.raw};
      for (int k = 1; k < STAGES; k++)
      begin
        stage_r[k] <= stage_r[k-1];
      end
    end
  end

  assign bus.pads = stage_r[STAGES-1][PIN_COUNT-1:0];
  assign bus.ext_sync = stage_r[STAGES-1][PIN_COUNT];
endmodule
`default_nettype wire

// ===== verilog/strap_sync_if.sv
// Raw and synchronised strap pin levels between synchroniser and latch
`timescale 1ns/100ps
`default_nettype none
interface strap_sync_if;
  logic [strap_cfg_pkg::PIN_COUNT-1:0] raw;
  logic ext_raw;
  logic [strap_cfg_pkg::PIN_COUNT-1:0] pads;
  logic ext_sync;
  modport sync_side (input raw, input ext_raw, output pads, output ext_sync);
  modport user_side (output raw, output ext_raw, input pads, input ext_sync);
endinterface
`default_nettype wire
